// ===== adc_slot_channel_sequencer_test.sv
// self-checking bench of the slot channel sequencer
// assumes zero-wait apb answers and the converter model beside the design
`timescale 1ns/1ps
module adc_slot_channel_sequencer_test import ascs_pkg::*;;
    logic pclk;
    logic presetn;
    ascs_apb_req_t req;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic err;
    logic pready;
    logic pslverr;
    logic conversion_start_pin;
    logic conv_phase_end;
    logic conv_busy;
    logic [4:0] mux_sel;
    logic [4:0] exp_q[$];
    int num_errors;
    int total_checks;
    int cycles;
    int seed;
    ascs_sequencer dut (.pclk(pclk), .presetn(presetn), .paddr(req.paddr), .psel(req.psel),
        .penable(req.penable), .pwrite(req.pwrite), .pwdata(req.pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conversion_start_pin(conversion_start_pin), .conv_phase_end(conv_phase_end),
        .mux_sel(mux_sel), .conv_busy(conv_busy));
    ascs_conv_model conv (.pclk(pclk), .conversion_start_pin(conversion_start_pin),
        .conv_phase_end(conv_phase_end));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic int rnd(input int m);
        return $unsigned($random(seed)) % m;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // idle cycle first, so a release and the next setup never share an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    // busy must rise after the start edge and drop once the phase has ended
    task automatic step();
        fork
            conv.convert(rnd(4));
            begin
                repeat (3) @(posedge pclk);
                #1;
                chk({31'h0, conv_busy}, 32'h0000_0001);
            end
        join
        @(posedge pclk);
        #1;
        chk({31'h0, conv_busy}, 32'h0000_0000);
    endtask
    // start point after a mode change is open, so lock onto the final entry first
    task automatic run_seq();
        int k;
        k = 0;
        while (mux_sel !== exp_q[$] && k < 300) begin
            step();
            k++;
        end
        for (int i = 0; i < 2 * exp_q.size(); i++) begin
            step();
            chk({27'h0, mux_sel}, {27'h0, exp_q[i % exp_q.size()]});
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [4:0] c;
        seed = 11075;
        presetn = 1'b0;
        req = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ASCS_OFF_CTRL, '0);
        chk(rd, 32'h0000_0001);
        apb(1'b0, ASCS_OFF_MASK, '0);
        chk(rd, {16'h0000, ASCS_MASK_RST});
        apb(1'b1, 12'h100, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h0000_0001);
        apb(1'b0, 12'h100, '0);
        chk(rd, '0);
        apb(1'b1, ASCS_OFF_MASK, 32'h0000_0012);
        chk({31'h0, err}, 32'h0000_0000);
        exp_q = '{5'h01, 5'h04};
        run_seq();
        // sensor joins the bitmask walk after the highest set input
        apb(1'b1, ASCS_OFF_CTRL, 32'h0000_0003);
        exp_q = '{5'h01, 5'h04, ASCS_SEL_TEMP};
        run_seq();
        exp_q = '{5'h05, 5'h09, 5'h0E, 5'h02, 5'h05, 5'h09, 5'h0E, 5'h0A, 5'h05, 5'h09, 5'h0E, ASCS_SEL_TEMP};
        for (int i = 0; i < 11; i++) apb(1'b1, ASCS_OFF_SLOT + 12'(4 * i), {27'h0, exp_q[i]});
        // slot past the count holds a stray code that must never show
        apb(1'b1, ASCS_OFF_SLOT + 12'h02C, 32'h0000_001F);
        apb(1'b0, ASCS_OFF_SLOT + 12'h02C, '0);
        chk(rd, 32'h0000_000F);
        apb(1'b1, ASCS_OFF_CTRL, 32'h0000_0A02);
        run_seq();
        // shorter list without the sensor; count shrinks while the position is past it
        exp_q = '{5'h05, 5'h09, 5'h0E, 5'h02};
        apb(1'b1, ASCS_OFF_CTRL, 32'h0000_0300);
        run_seq();
        apb(1'b0, ASCS_OFF_STATUS, '0);
        chk(rd, {8'h00, 1'h0, 7'h03, 8'h00, 3'h0, 5'h02});
        exp_q.delete();
        for (int i = 0; i < 128; i++) begin
            exp_q.push_back(5'(rnd(16)));
            apb(1'b1, ASCS_OFF_SLOT + 12'(4 * i), {27'h0, exp_q[i]});
        end
        exp_q.push_back(ASCS_SEL_TEMP);
        apb(1'b1, ASCS_OFF_CTRL, 32'h0000_7F02);
        run_seq();
        // longer than the slot list: command mode has no length limit
        apb(1'b1, ASCS_OFF_CTRL, 32'h0000_0004);
        for (int i = 0; i < 300; i++) begin
            c = 5'(rnd(16));
            apb(1'b1, ASCS_OFF_CMD, {27'h0, c});
            step();
            chk({27'h0, mux_sel}, {27'h0, c});
        end
        final_report();
    end
endmodule

// ===== ascs_conv_model.sv
// far-side converter model: raises the start pin and ends each conversion phase
// assumes the sequencer takes the start edge within two cycles
`timescale 1ns/1ps
module ascs_conv_model (
    // clock
    input wire logic pclk,
    // converter side
    output logic conversion_start_pin,
    output logic conv_phase_end
);
    initial begin
        conversion_start_pin = 1'b0;
        conv_phase_end = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // one conversion; slow stretches the phase, so prompt and slow answers both occur
    task automatic convert(input int slow);
        @(posedge pclk);
        conversion_start_pin <= 1'b1;
        repeat (3 + slow) @(posedge pclk);
        conv_phase_end <= 1'b1;
        @(posedge pclk);
        conv_phase_end <= 1'b0;
        conversion_start_pin <= 1'b0;
    endtask
endmodule

// ===== ascs_pkg.sv
// constants, field layouts and carrier types of the slot channel sequencer
// assumes a 32-bit apb bus and a single 100 MHz clock domain
package ascs_pkg;

    // register byte offsets
    localparam logic [11:0] ASCS_OFF_CTRL = 12'h000;
    localparam logic [11:0] ASCS_OFF_MASK = 12'h004;
    localparam logic [11:0] ASCS_OFF_CMD = 12'h008;
    localparam logic [11:0] ASCS_OFF_STATUS = 12'h00C;
    localparam logic [11:0] ASCS_OFF_SLOT = 12'h200;
    localparam logic [11:0] ASCS_SLOT_SPAN = 12'h200;

    // sizes
    localparam int ASCS_NUM_SLOTS = 128;
    localparam int ASCS_POS_W = 7;
    localparam int ASCS_SLOT_W = 4;
    localparam int ASCS_SEL_W = 5;
    localparam int ASCS_NUM_IN = 16;

    // mux code of the temperature sensor, outside the reach of a slot entry
    localparam logic [4:0] ASCS_SEL_TEMP = 5'h10;

    // ctrl fields
    localparam int ASCS_CTRL_STD_EN = 0;
    localparam int ASCS_CTRL_TEMP_EN = 1;
    localparam int ASCS_CTRL_CMD_MODE = 2;
    localparam int ASCS_CTRL_CNT_LSB = 8;
    localparam int ASCS_CTRL_CNT_MSB = 14;

    // status fields
    localparam int ASCS_ST_SEL_LSB = 0;
    localparam int ASCS_ST_BUSY = 8;
    localparam int ASCS_ST_POS_LSB = 16;
    localparam int ASCS_ST_TEMP = 23;

    // reset values
    localparam logic [15:0] ASCS_MASK_RST = 16'h0001;
    localparam logic ASCS_STD_EN_RST = 1'b1;

    typedef struct packed {
        logic std_en;
        logic temp_en;
        logic cmd_mode;
        logic [6:0] slot_cnt_m1;
    } ascs_ctrl_t;

    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } ascs_apb_req_t;

    typedef enum logic {
        ASCS_IDLE,
        ASCS_CONV
    } ascs_state_t;

endpackage

// ===== ascs_sequencer.sv
// channel sequencer of a multiplexed converter: slot list, bitmask and command modes
// assumes synchronous conversion start and end-of-conversion inputs, apb master on pclk
//
// How it works
// R1: slot-list length never exceeds implemented slot count
// R2: command mode: host picks each channel, unlimited
// R3: bitmask enable cleared selects slot-list ordering
// R4: slot count field holds used slots minus one
// R5: slot entries cannot select the temperature sensor
// R6: temp enable appends one sensor conversion per iteration
// R7: mux selection updates at end of conversion phase
// R8: each start advances one position, wraps to zero
`timescale 1ns/1ps
module ascs_sequencer import ascs_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter side
    input wire logic conversion_start_pin,
    input wire logic conv_phase_end,
    output logic [4:0] mux_sel,
    output logic conv_busy
);

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // next enabled input above cur in the bitmask; 5'h1f when none is left
    function automatic logic [4:0] next_in_mask(input logic [15:0] mask, input logic [4:0] cur);
        logic [4:0] res;
        res = 5'h1F;
        for (int i = ASCS_NUM_IN - 1; i >= 0; i--) begin
            if (mask[i] && (5'(i) > cur)) begin
                res = 5'(i);
            end
        end
        return res;
    endfunction

    function automatic logic [4:0] first_in_mask(input logic [15:0] mask);
        logic [4:0] res;
        res = 5'h00;
        for (int i = ASCS_NUM_IN - 1; i >= 0; i--) begin
            if (mask[i]) begin
                res = 5'(i);
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers

    ascs_apb_req_t req;
    ascs_ctrl_t ctrl_ff;
    logic [15:0] mask_ff;
    logic [4:0] cmd_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    ascs_state_t state_ff;
    logic [6:0] pos_ff;
    logic temp_ff;
    logic [4:0] sel_ff;
    logic start_d_ff;

    assign req = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite, pwdata: pwdata};

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    wire setup_ph = req.psel && !req.penable;
    wire wr_acc = req.psel && req.penable && req.pwrite;
    wire hit_ctrl = req.paddr == ASCS_OFF_CTRL;
    wire hit_mask = req.paddr == ASCS_OFF_MASK;
    wire hit_cmd = req.paddr == ASCS_OFF_CMD;
    wire hit_stat = req.paddr == ASCS_OFF_STATUS;
    wire hit_slot = (req.paddr >= ASCS_OFF_SLOT) && (req.paddr < ASCS_OFF_SLOT + ASCS_SLOT_SPAN)
        && (req.paddr[1:0] == 2'b00);
    wire hit_any = hit_ctrl | hit_mask | hit_cmd | hit_stat | hit_slot;
    wire [11:0] slot_off = req.paddr - ASCS_OFF_SLOT;
    wire [6:0] bus_idx = slot_off[8:2];
    wire [3:0] bus_slot;
    wire [3:0] seq_slot;

    // a status write is ignored but still answered without error
    wire [31:0] rd_word =
        hit_ctrl ? {17'h0_0000, ctrl_ff.slot_cnt_m1, 5'h00, ctrl_ff.cmd_mode, ctrl_ff.temp_en, ctrl_ff.std_en} :
        hit_mask ? {16'h0000, mask_ff} :
        hit_cmd ? {27'h000_0000, cmd_ff} :
        hit_stat ? {8'h00, temp_ff, pos_ff, 7'h00, (state_ff == ASCS_CONV), 3'h0, sel_ff} :
        hit_slot ? {28'h000_0000, bus_slot} : 32'h0000_0000;

    // read data is caught in the setup cycle, so the access cycle answers at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
        end else if (setup_ph) begin
            prdata_ff <= req.pwrite ? 32'h0000_0000 : rd_word;
            pslverr_ff <= !hit_any;
        end
    end

    assign pready = req.psel && req.penable;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff && pready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= '{std_en: ASCS_STD_EN_RST, temp_en: 1'b0, cmd_mode: 1'b0, slot_cnt_m1: '0};
            mask_ff <= ASCS_MASK_RST;
            cmd_ff <= '0;
        end else if (wr_acc) begin
            if (hit_ctrl) begin
                ctrl_ff.std_en <= req.pwdata[ASCS_CTRL_STD_EN];
                ctrl_ff.temp_en <= req.pwdata[ASCS_CTRL_TEMP_EN];
                ctrl_ff.cmd_mode <= req.pwdata[ASCS_CTRL_CMD_MODE];
                ctrl_ff.slot_cnt_m1 <= req.pwdata[ASCS_CTRL_CNT_MSB:ASCS_CTRL_CNT_LSB];
            end
            if (hit_mask) begin
                mask_ff <= req.pwdata[15:0];
            end
            if (hit_cmd) begin
                cmd_ff <= req.pwdata[4:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    wire start_evt = conversion_start_pin && !start_d_ff;
    wire step = (state_ff == ASCS_CONV) && conv_phase_end;
    wire slot_mode = !ctrl_ff.cmd_mode && !ctrl_ff.std_en; // R3
    // the field covers exactly the implemented slots, so the list cannot run past them
    wire slot_last = pos_ff >= ctrl_ff.slot_cnt_m1; // R1 R4
    wire [4:0] mask_nxt = next_in_mask(mask_ff, sel_ff);
    wire [4:0] mask_first = first_in_mask(mask_ff);
    wire mask_end = temp_ff || (mask_nxt == 5'h1F);

    logic [6:0] nxt_pos;
    logic nxt_temp;
    logic [4:0] nxt_sel;

    always_comb begin
        nxt_pos = pos_ff;
        nxt_temp = 1'b0;
        nxt_sel = sel_ff;
        if (ctrl_ff.cmd_mode) begin
            // no position count is kept, the host sequence has no length limit
            nxt_pos = '0; // R2
            nxt_sel = cmd_ff; // R2
        end else if (slot_mode) begin
            if (!temp_ff && slot_last && ctrl_ff.temp_en) begin
                nxt_temp = 1'b1; // R6
                nxt_sel = ASCS_SEL_TEMP; // R6
            end else begin
                nxt_pos = (temp_ff || slot_last) ? 7'h00 : pos_ff + 7'h01; // R8
                nxt_sel = {1'b0, seq_slot}; // R5
            end
        end else begin
            if (!temp_ff && mask_nxt == 5'h1F && ctrl_ff.temp_en) begin
                nxt_temp = 1'b1; // R6
                nxt_sel = ASCS_SEL_TEMP;
            end else begin
                nxt_sel = mask_end ? mask_first : mask_nxt; // R8
            end
            nxt_pos = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ASCS_IDLE;
            start_d_ff <= 1'b0;
            pos_ff <= '0;
            temp_ff <= 1'b0;
            sel_ff <= '0;
        end else begin
            start_d_ff <= conversion_start_pin;
            case (state_ff)
                ASCS_IDLE: begin
                    if (start_evt) begin
                        state_ff <= ASCS_CONV; // R8
                    end
                end
                ASCS_CONV: begin
                    if (conv_phase_end) begin
                        state_ff <= ASCS_IDLE;
                        pos_ff <= nxt_pos; // R8
                        temp_ff <= nxt_temp;
                        sel_ff <= nxt_sel; // R7
                    end
                end
                default: begin
                    state_ff <= ASCS_IDLE;
                end
            endcase
        end
    end

    assign mux_sel = sel_ff;
    assign conv_busy = (state_ff == ASCS_CONV);

    ascs_slot_store u_store (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_acc && hit_slot),
        .wr_idx(bus_idx),
        .wr_data(req.pwdata[3:0]),
        .bus_idx(bus_idx),
        .bus_data(bus_slot),
        .seq_idx(nxt_pos),
        .seq_data(seq_slot)
    );

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    slot_pos_bound_a: assert property (step && slot_mode && !nxt_temp |=> pos_ff <= $past(ctrl_ff.slot_cnt_m1)) // R1
        else $error("slot position beyond programmed count");
    cmd_follow_a: assert property (step && ctrl_ff.cmd_mode |=> mux_sel == $past(cmd_ff)) // R2
        else $error("command mode channel not taken");
    mode_select_a: assert property (step && slot_mode && !temp_ff && !slot_last |=> pos_ff == $past(pos_ff) + 7'h01) // R3
        else $error("slot list did not step");
    count_wrap_a: assert property (step && slot_mode && slot_last && !ctrl_ff.temp_en |=> pos_ff == 7'h00) // R4
        else $error("slot list did not wrap after last slot");
    temp_slot_a: assert property (step && slot_mode && !nxt_temp |=> mux_sel[4] == 1'b0) // R5
        else $error("slot entry reached the sensor");
    temp_append_a: assert property (step && slot_mode && slot_last && ctrl_ff.temp_en && !temp_ff // R6
        |=> mux_sel == ASCS_SEL_TEMP && temp_ff)
        else $error("sensor conversion not appended");
    mux_hold_a: assert property (!step |=> $stable(mux_sel)) // R7
        else $error("mux moved outside end of conversion");
    start_conv_a: assert property (start_evt && !conv_busy |=> conv_busy) // R8
        else $error("start not taken");

    cov_temp_c: cover property (step && nxt_temp);
    cov_wrap_c: cover property (step && slot_mode && slot_last);
    cov_cmd_c: cover property (step && ctrl_ff.cmd_mode);
    cov_err_c: cover property (pready && pslverr);

endmodule

// ===== ascs_slot_store.sv
// slot list storage: one channel entry per slot, flip-flops addressed by index
// assumes the writer holds the write strobe for one cycle per update
`timescale 1ns/1ps
module ascs_slot_store import ascs_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // write port
    input wire logic wr_en,
    input wire logic [6:0] wr_idx,
    input wire logic [3:0] wr_data,
    // read ports
    input wire logic [6:0] bus_idx,
    output logic [3:0] bus_data,
    input wire logic [6:0] seq_idx,
    output logic [3:0] seq_data
);

    // entries are four bits wide, so no slot can ever name the sensor
    logic [3:0] slot_ff [ASCS_NUM_SLOTS];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < ASCS_NUM_SLOTS; i++) begin
                slot_ff[i] <= '0;
            end
        end else if (wr_en) begin
            slot_ff[wr_idx] <= wr_data;
        end
    end

    assign bus_data = slot_ff[bus_idx];
    assign seq_data = slot_ff[seq_idx];

endmodule
